// ===== hw/pca_top.sv
`timescale 1ns/10ps
// Overview of operation
// RL1: Main counter is 16 bits, accessed as separate low and high bytes.
// RL2: Reading low byte latches high byte; next high read returns latch.
// RL3: Reads never disturb counting.
// RL4: Timebase select picks div12, div4, timer0 overflow, ext edges, sys, osc/8.
// RL5: External count input levels must last two system clocks.
// RL6: Oscillator/8 source is synchronised; oscillator no faster than clock.
// RL7: Wrap FFFF to 0000 sets overflow flag; interrupt if enabled.
// RL8: Overflow flag stays set until software writes zero.
// RL9: Interrupt reaches CPU only with global and group enables set.
// RL10: With idle control zero, counting continues during CPU idle.
// RL11: Overflow during a read-modify-write of control register is lost.
// RL12: Software recovers lost overflow by sampling high byte around bit ops.
// RL13: Five modules, each with 16-bit register and own I/O line.
// RL14: Capture bits choose rising, falling or either edge capture.
// RL15: Compare enable with match/toggle/modulation bits picks compare modes.
// RL16: Module interrupt enable lets module flag raise a request.
// RL17: Capture loads counter into module register and sets module flag.
// RL18: Module line levels must last two system clocks to be valid.
// RL19: Software timer match sets module flag; software clears it.
// RL20: Low byte write clears compare enable; high byte write sets it.
// RL21: High-speed output toggles the line on each 16-bit match.
// RL22: Frequency output high byte gives array clocks between toggles.
// RL23: Low byte match toggles output and adds high byte; zero means 256.
// RL24: 8-bit PWM: high on low-byte match, low on wrap, reload from high.
// RL25: 16-bit PWM: high on 16-bit match, low on counter overflow.
// RL26: With idle control one, array suspends while CPU idles; the code stops only counting and compare, capture still loads and flags.
// RL27: Counter advances by one per timebase tick; edges sensed synchronously.
module pca_top #(
  parameter int NUM_MOD = 5
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // Register port
  input  pca_pkg::pca_req_s     req_in,
  output logic [7:0]            rdata_out,
  // CPU state and enables
  input  wire logic             cpu_idle_in,
  input  wire logic             global_interrupt_enable_in,
  input  wire logic             array_group_interrupt_enable_in,
  output logic                  irq_out,
  // Count sources
  input  wire logic             timer0_overflow_in,
  input  wire logic             external_count_input_in,
  input  wire logic             ext_osc_in,
  // Module I/O lines
  input  wire logic [NUM_MOD-1:0] module_io_line_in,
  output logic [NUM_MOD-1:0]    module_io_line_out
);

  initial begin
    if (NUM_MOD < 1 || NUM_MOD > 5) begin
      $error("pca_top: NUM_MOD must be 1 to 5");
    end
  end

  // ===========================================================
  // State
  // ===========================================================
  typedef struct packed {
    logic [15:0]              cnt;
    logic [7:0]               snap;
    logic [7:0]               mode;
    logic                     ovf_flag;
    logic                     run;
    logic [NUM_MOD-1:0]       mflag;
    logic [NUM_MOD-1:0][7:0]  mctl;
    logic [NUM_MOD-1:0][15:0] mreg;
    logic [NUM_MOD-1:0]       mout;
    logic [NUM_MOD-1:0]       line_q1;
    logic [NUM_MOD-1:0]       line_q2;
    logic [NUM_MOD-1:0]       line_q3;
    logic                     eci_q1;
    logic                     eci_q2;
    logic                     eci_q3;
    logic                     osc_q1;
    logic                     osc_q2;
    logic                     osc_q3;
    logic [2:0]               osc_div;
    logic [3:0]               div;
    logic [7:0]               rdata;
  } pca_state_s;

  pca_state_s st_r;
  pca_state_s st_nxt;

  logic       tick;
  logic       wrap;
  logic       lo_wrap;
  logic [2:0] tb;
  logic       osc_rise;
  logic       rise;
  logic       fall;
  logic       hit16;
  logic       hit8;
  logic [7:0] cm;
  logic [7:0] step;

  // ===========================================================
  // Next-state logic
  // ===========================================================
  always_comb begin
    st_nxt   = st_r;
    tb       = st_r.mode[pca_pkg::MD_TB_LSB +: 3];
    osc_rise = 1'b0;
    tick     = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    hit16    = 1'b0;
    hit8     = 1'b0;
    cm       = 8'h00;
    step     = 8'h00;

    // Synchronisers; only the second and third stages are examined
    st_nxt.line_q1 = module_io_line_in;
    st_nxt.line_q2 = st_r.line_q1;
    st_nxt.line_q3 = st_r.line_q2;
    st_nxt.eci_q1  = external_count_input_in;
    st_nxt.eci_q2  = st_r.eci_q1;
    st_nxt.eci_q3  = st_r.eci_q2;
    st_nxt.osc_q1  = ext_osc_in;                             // [RL6]
    st_nxt.osc_q2  = st_r.osc_q1;
    st_nxt.osc_q3  = st_r.osc_q2;
    osc_rise = st_r.osc_q2 && !st_r.osc_q3;
    if (osc_rise) begin
      st_nxt.osc_div = st_r.osc_div + 3'h1;
    end

    // Timebase tick; idle suspends only when idle control is set
    if (st_r.run && !(cpu_idle_in && st_r.mode[pca_pkg::MD_IDLE_BIT])) begin
      st_nxt.div = (st_r.div == pca_pkg::DIV12_LAST) ? 4'h0
                   : st_r.div + 4'h1;                      // [RL10] [RL26]
      case (tb)                                              // [RL4]
        pca_pkg::PCA_TB_DIV12: tick = (st_r.div == pca_pkg::DIV12_LAST);
        pca_pkg::PCA_TB_DIV4:  tick = (st_r.div[1:0] ==
                                       pca_pkg::DIV4_LAST[1:0]);
        pca_pkg::PCA_TB_T0OVF: tick = timer0_overflow_in;
        pca_pkg::PCA_TB_EXT:   tick = st_r.eci_q3 && !st_r.eci_q2; // [RL27]
        pca_pkg::PCA_TB_SYS:   tick = 1'b1;
        pca_pkg::PCA_TB_OSC8:  tick = osc_rise &&
                                      (st_r.osc_div == pca_pkg::DIV8_LAST);
        default:               tick = 1'b0;
      endcase
    end

    // Counter advance; reads have no effect on it
    wrap    = tick && (st_r.cnt == pca_pkg::CNT_TOP);
    lo_wrap = tick && (st_r.cnt[7:0] == pca_pkg::LO_TOP);
    if (tick) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;                      // [RL1] [RL3] [RL27]
    end

    // Overflow flag, lost under a read-modify-write of control
    if (wrap && !req_in.rmw) begin
      st_nxt.ovf_flag = 1'b1;                                // [RL7] [RL11]
    end

    // Modules act on the count before this tick's increment
    for (int i = 0; i < NUM_MOD; i++) begin
      cm    = st_r.mctl[i];
      rise  = st_r.line_q2[i] && !st_r.line_q3[i];
      fall  = !st_r.line_q2[i] && st_r.line_q3[i];
      hit16 = tick && (st_r.cnt == st_r.mreg[i]);
      hit8  = tick && (st_r.cnt[7:0] == st_r.mreg[i][7:0]);
      step  = st_r.mreg[i][15:8];
      if (!cm[pca_pkg::CM_MATCH] && !cm[pca_pkg::CM_TOGGLE] &&
          !cm[pca_pkg::CM_MOD] &&
          ((cm[pca_pkg::CM_RISE] && rise) ||
           (cm[pca_pkg::CM_FALL] && fall))) begin
        st_nxt.mreg[i]  = st_r.cnt;                          // [RL14] [RL17]
        st_nxt.mflag[i] = 1'b1;
      end else if (cm[pca_pkg::CM_COMP_EN] && !cm[pca_pkg::CM_RISE] &&
                   !cm[pca_pkg::CM_FALL]) begin              // [RL15]
        if (cm[pca_pkg::CM_MOD] && cm[pca_pkg::CM_TOGGLE]) begin
          if (hit8) begin
            st_nxt.mout[i]        = !st_r.mout[i];           // [RL22] [RL23]
            st_nxt.mreg[i][7:0]   = st_r.mreg[i][7:0] + step;
          end
        end else if (cm[pca_pkg::CM_MOD] && cm[pca_pkg::CM_WIDE]) begin
          if (wrap) begin
            st_nxt.mout[i] = 1'b0;                           // [RL25]
          end else if (hit16) begin
            st_nxt.mout[i] = 1'b1;
          end
          if (hit16 && cm[pca_pkg::CM_MATCH]) begin
            st_nxt.mflag[i] = 1'b1;
          end
        end else if (cm[pca_pkg::CM_MOD]) begin
          if (lo_wrap) begin
            st_nxt.mout[i]      = 1'b0;                      // [RL24]
            st_nxt.mreg[i][7:0] = step;
          end else if (hit8) begin
            st_nxt.mout[i] = 1'b1;
          end
        end else if (cm[pca_pkg::CM_MATCH] && hit16) begin
          st_nxt.mflag[i] = 1'b1;                            // [RL19]
          if (cm[pca_pkg::CM_TOGGLE]) begin
            st_nxt.mout[i] = !st_r.mout[i];                  // [RL21]
          end
        end
      end
    end

    // Register reads; low-byte read latches the high byte
    st_nxt.rdata = 8'h00;
    if (req_in.rd) begin
      case (req_in.sel)
        pca_pkg::SEL_CNT_LO: begin
          st_nxt.rdata = st_r.cnt[7:0];
          st_nxt.snap  = st_r.cnt[15:8];                     // [RL2]
        end
        pca_pkg::SEL_CNT_HI:  st_nxt.rdata = st_r.snap;      // [RL2]
        pca_pkg::SEL_MODE:    st_nxt.rdata = st_r.mode;
        pca_pkg::SEL_CTRL:    st_nxt.rdata = {st_r.ovf_flag, st_r.run,
                                 {(6-NUM_MOD){1'b0}}, st_r.mflag};
        pca_pkg::SEL_MOD_CTL: st_nxt.rdata = (req_in.idx < NUM_MOD) ?
                                 st_r.mctl[req_in.idx] : 8'h00;
        pca_pkg::SEL_MOD_LO:  st_nxt.rdata = (req_in.idx < NUM_MOD) ?
                                 st_r.mreg[req_in.idx][7:0] : 8'h00;
        pca_pkg::SEL_MOD_HI:  st_nxt.rdata = (req_in.idx < NUM_MOD) ?
                                 st_r.mreg[req_in.idx][15:8] : 8'h00;
        default:              st_nxt.rdata = 8'h00;
      endcase
    end

    // Register writes; software clears flags but a same-cycle set wins, except on a module flag already set
    if (req_in.wr) begin
      case (req_in.sel)
        pca_pkg::SEL_CNT_LO: st_nxt.cnt[7:0]  = req_in.wdata;
        pca_pkg::SEL_CNT_HI: st_nxt.cnt[15:8] = req_in.wdata;
        pca_pkg::SEL_MODE:   st_nxt.mode = {req_in.wdata[7], 3'h0,
                                            req_in.wdata[3:0]};
        pca_pkg::SEL_CTRL: begin
          st_nxt.run      = req_in.wdata[pca_pkg::CN_RUN];
          st_nxt.ovf_flag = req_in.wdata[pca_pkg::CN_OVF_FLAG] ||
                            (wrap && !req_in.rmw);            // [RL8]
          for (int i = 0; i < NUM_MOD; i++) begin
            st_nxt.mflag[i] = req_in.wdata[i] || (st_nxt.mflag[i] &&
                              !st_r.mflag[i]);
          end
        end
        pca_pkg::SEL_MOD_CTL: if (req_in.idx < NUM_MOD) begin
          st_nxt.mctl[req_in.idx] = req_in.wdata;
        end
        pca_pkg::SEL_MOD_LO: if (req_in.idx < NUM_MOD) begin
          st_nxt.mreg[req_in.idx][7:0] = req_in.wdata;
          st_nxt.mctl[req_in.idx][pca_pkg::CM_COMP_EN] = 1'b0; // [RL20]
        end
        pca_pkg::SEL_MOD_HI: if (req_in.idx < NUM_MOD) begin
          st_nxt.mreg[req_in.idx][15:8] = req_in.wdata;
          st_nxt.mctl[req_in.idx][pca_pkg::CM_COMP_EN] = 1'b1; // [RL20]
        end
        default: ;
      endcase
    end
  end

  // ===========================================================
  // State register
  // ===========================================================
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ===========================================================
  // Outputs
  // ===========================================================
  logic req_any;

  // Any enabled flag, then both global gates
  always_comb begin
    req_any = st_r.ovf_flag && st_r.mode[pca_pkg::MD_OVF_IE]; // [RL7]
    for (int i = 0; i < NUM_MOD; i++) begin
      req_any = req_any ||
                (st_r.mflag[i] && st_r.mctl[i][pca_pkg::CM_IE]); // [RL16]
    end
  end

  assign irq_out = req_any && global_interrupt_enable_in &&
                   array_group_interrupt_enable_in;          // [RL9]
  assign rdata_out          = st_r.rdata;
  assign module_io_line_out = st_r.mout;                     // [RL13]

endmodule : pca_top

// ===== hw/pca_pkg.sv
package pca_pkg;

  // ===========================================================
  // Register selects on the special function register port
  // ===========================================================
  localparam logic [3:0] SEL_CNT_LO   = 4'h0;
  localparam logic [3:0] SEL_CNT_HI   = 4'h1;
  localparam logic [3:0] SEL_MODE     = 4'h2;
  localparam logic [3:0] SEL_CTRL     = 4'h3;
  localparam logic [3:0] SEL_MOD_CTL  = 4'h4;
  localparam logic [3:0] SEL_MOD_LO   = 4'h5;
  localparam logic [3:0] SEL_MOD_HI   = 4'h6;

  // ===========================================================
  // Field positions
  // ===========================================================
  localparam int MD_IDLE_BIT = 7;
  localparam int MD_TB_LSB   = 1;
  localparam int MD_OVF_IE   = 0;
  localparam int CN_OVF_FLAG = 7;
  localparam int CN_RUN      = 6;
  localparam int CM_WIDE     = 7;
  localparam int CM_COMP_EN  = 6;
  localparam int CM_RISE     = 5;
  localparam int CM_FALL     = 4;
  localparam int CM_MATCH    = 3;
  localparam int CM_TOGGLE   = 2;
  localparam int CM_MOD      = 1;
  localparam int CM_IE       = 0;

  // ===========================================================
  // Reset values and timebase constants
  // ===========================================================
  localparam logic [7:0]  MODE_RST    = 8'h00;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  localparam logic [15:0] CNT_TOP     = 16'hFFFF;
  localparam logic [7:0]  LO_TOP      = 8'hFF;
  localparam logic [3:0]  DIV12_LAST  = 4'hB;
  localparam logic [3:0]  DIV4_LAST   = 4'h3;
  localparam logic [2:0]  DIV8_LAST   = 3'h7;

  typedef enum logic [2:0] {
    PCA_TB_DIV12 = 3'h0,
    PCA_TB_DIV4  = 3'h1,
    PCA_TB_T0OVF = 3'h2,
    PCA_TB_EXT   = 3'h3,
    PCA_TB_SYS   = 3'h4,
    PCA_TB_OSC8  = 3'h5
  } pca_tb_e;

  // Register-port request carrier
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       rmw;
    logic [3:0] sel;
    logic [2:0] idx;
    logic [7:0] wdata;
  } pca_req_s;

endpackage : pca_pkg

// ===== tb/pca_far.sv
`timescale 1ns/10ps
// ==========================================
// Far side: count sources and module lines
module pca_far (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Module line levels asked for by the bench
  input  wire logic [4:0] lvl_in,
  // Sources seen by the array
  output logic            t0_ovf_out,
  output logic            eci_out,
  output logic            osc_out,
  output logic [4:0]      line_out
);
  logic [2:0] cnt_r = 3'h0;
  logic       osc_r = 1'b0;
  logic [4:0] line_r = 5'h00;
  // Start defined so no source floats before the first edge
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 3'h0;
      osc_r <= 1'b0;
      line_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      osc_r <= ~osc_r; // Half the system rate
      line_r <= lvl_in; // Bench holds each level at least 8 clocks
    end
  end
  // Count input spends 4 clocks at each level
  assign eci_out = cnt_r[2];
  assign t0_ovf_out = (cnt_r == 3'h7);
  assign osc_out = osc_r;
  assign line_out = line_r;
endmodule : pca_far

// ===== tb/pca_top_sva.sv
`timescale 1ns/10ps
// ==========================================
// Port checker for the counter array
module pca_chk #(
  parameter int NUM_MOD = 5
) (
  // Clock, reset and register port
  input wire logic               sys_clk_in,
  input wire logic               rst_in,
  input pca_pkg::pca_req_s       req_in,
  input wire logic [7:0]         rdata_out,
  // CPU state, enables and outputs
  input wire logic               cpu_idle_in,
  input wire logic               global_interrupt_enable_in,
  input wire logic               array_group_interrupt_enable_in,
  input wire logic               irq_out,
  input wire logic [NUM_MOD-1:0] module_io_line_out
);
  logic [7:0] md_r;
  logic [7:0] cm_r [NUM_MOD];
  logic       frz_r;
  logic       ie_any;
  wire  rd  = req_in.rd;
  wire  wr  = req_in.wr;
  wire  ok  = req_in.idx < 3'(NUM_MOD);
  wire  en  = global_interrupt_enable_in && array_group_interrupt_enable_in;
  wire  frz = md_r[7] && cpu_idle_in && !wr;
  // Any module interrupt enable written by software
  always_comb begin
    ie_any = 1'b0;
    for (int i = 0; i < NUM_MOD; i++)
      ie_any = ie_any | cm_r[i][0];
  end
  // Shadow what software wrote; needed since bodies are hidden
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      md_r <= pca_pkg::MODE_RST;
      frz_r <= 1'b0;
      for (int i = 0; i < NUM_MOD; i++)
        cm_r[i] <= 8'h00;
    end else begin
      frz_r <= frz;
      if (wr && req_in.sel == pca_pkg::SEL_MODE)
        md_r <= req_in.wdata & 8'h8F;
      if (wr && ok && req_in.sel == pca_pkg::SEL_MOD_CTL)
        cm_r[req_in.idx] <= req_in.wdata;
      if (wr && ok && req_in.sel == pca_pkg::SEL_MOD_LO)
        cm_r[req_in.idx][6] <= 1'b0;
      if (wr && ok && req_in.sel == pca_pkg::SEL_MOD_HI)
        cm_r[req_in.idx][6] <= 1'b1;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_rdata_quiet: assert property (!rd |=> rdata_out == 8'h00)
    else $error("read data without a read");
  a_irq_gate: assert property (irq_out |-> en)
    else $error("request passed closed enables");
  a_irq_source: assert property (irq_out |-> md_r[0] || ie_any)
    else $error("request with no source enabled");
  a_flag_sticky: assert property (irq_out && !wr ##1 en |-> irq_out)
    else $error("request dropped without a write");
  a_refuse_idx: assert property (rd && !ok && req_in.sel >=
    pca_pkg::SEL_MOD_CTL |=> rdata_out == 8'h00)
    else $error("missing module read not zero");
  a_mode_read: assert property (rd && req_in.sel == pca_pkg::SEL_MODE
    |=> rdata_out == $past(md_r)) else $error("mode readback wrong");
  a_ctl_read: assert property (rd && ok && req_in.sel ==
    pca_pkg::SEL_MOD_CTL |=> rdata_out == $past(cm_r[req_in.idx]))
    else $error("module control readback wrong");
  a_idle_freeze: assert property (frz && frz_r |=>
    $stable(module_io_line_out)) else $error("lines moved while suspended");
  c_irq: cover property (irq_out);
  c_freeze: cover property (frz && frz_r);
  c_snap: cover property (rd && req_in.sel == pca_pkg::SEL_CNT_HI);
endmodule : pca_chk

bind pca_top pca_chk #(.NUM_MOD(NUM_MOD)) u_pca_chk (.sys_clk_in, .rst_in,
  .req_in, .rdata_out, .cpu_idle_in, .global_interrupt_enable_in,
  .array_group_interrupt_enable_in, .irq_out, .module_io_line_out);

// ===== tb/pca_top_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL t=%0t got %0h exp %0h", $time, g, e); end end
// ==========================================
// Bench for the counter array
module pca_top_bench;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  pca_pkg::pca_req_s req = '0;
  logic              idle = 1'b0;
  logic              gie = 1'b0;
  logic              grp = 1'b0;
  logic [4:0]        lvl = 5'h00;
  logic [7:0]        rdata, v, w;
  logic              irq, t0, external_count_input, osc;
  logic [4:0]        line_in, line_out;
  logic [15:0]       n;
  int                miscompares = 0;
  int                tests_run = 0;
  int                cyc = 0;
  logic [7:0]  tb_md [8] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A,
                             8'h88, 8'h08};
  int          tb_ex [8] = '{20, 60, 30, 30, 242, 15, 0, 242};
  bit   [7:0]  tb_idl = 8'hC0;
  logic [15:0] cap_ex [3] = '{16'h1234, 16'h5678, 16'h5678};

  pca_top u_pca_top (.sys_clk_in(clk), .rst_in(rst), .req_in(req),
    .rdata_out(rdata), .cpu_idle_in(idle), .global_interrupt_enable_in(gie),
    .array_group_interrupt_enable_in(grp), .irq_out(irq),
    .timer0_overflow_in(t0), .external_count_input_in(external_count_input),
    .ext_osc_in(osc), .module_io_line_in(line_in),
    .module_io_line_out(line_out));
  pca_far u_pca_far (.clk_in(clk), .rst_in(rst), .lvl_in(lvl),
    .t0_ovf_out(t0), .eci_out(external_count_input), .osc_out(osc), .line_out(line_in));

  // 200 MHz system clock
  initial forever #2.5 clk = ~clk;

  // One access, taken at the next edge; idle cycle after keeps it apart
  task automatic acc(input logic r, input logic [3:0] s, input logic [2:0] i,
                     input logic [7:0] d);
    @(posedge clk);
    req.rd <= r;
    req.wr <= !r;
    req.sel <= s;
    req.idx <= i;
    req.wdata <= d;
    @(posedge clk);
    req <= '0;
    #1 v = rdata;
  endtask : acc
  task automatic wr(input logic [3:0] s, input logic [2:0] i,
                    input logic [7:0] d);
    acc(1'b0, s, i, d);
  endtask : wr
  task automatic rc(input logic [3:0] s, input logic [2:0] i,
                    input logic [7:0] e);
    acc(1'b1, s, i, 8'h00);
    `CHK(v, e)
  endtask : rc
  task automatic ck_irq(input logic e);
    #1;
    `CHK(irq, e)
  endtask : ck_irq
  task give_verdict;
    $display("comparisons %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Cut a hang short; the tests need about 2300 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // Test sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rc(pca_pkg::SEL_MODE, 3'h0, pca_pkg::MODE_RST);
    rc(pca_pkg::SEL_CTRL, 3'h0, 8'h00);
    rc(pca_pkg::SEL_MOD_CTL, 3'h5, 8'h00);
    $display("test reset done");
    // Every timebase, then suspended and not suspended while idle
    for (int k = 0; k < 8; k++) begin
      wr(pca_pkg::SEL_CNT_LO, 3'h0, 8'h00);
      wr(pca_pkg::SEL_CNT_HI, 3'h0, 8'h00);
      rc(pca_pkg::SEL_CNT_LO, 3'h0, 8'h00);
      wr(pca_pkg::SEL_MODE, 3'h0, tb_md[k]);
      @(posedge clk);
      idle <= tb_idl[k];
      wr(pca_pkg::SEL_CTRL, 3'h0, 8'h40);
      repeat (240) @(posedge clk);
      wr(pca_pkg::SEL_CTRL, 3'h0, 8'h00);
      @(posedge clk);
      idle <= 1'b0;
      acc(1'b1, pca_pkg::SEL_CNT_LO, 3'h0, 8'h00);
      w = v;
      acc(1'b1, pca_pkg::SEL_CNT_HI, 3'h0, 8'h00);
      n = {v, w};
      `CHK(n + 16'd3 >= tb_ex[k] && n <= tb_ex[k] + 3, 1'b1)
    end
    $display("test timebase done");
    // Snapshot, then overflow flag and its enables
    wr(pca_pkg::SEL_CNT_LO, 3'h0, 8'hF0);
    wr(pca_pkg::SEL_CNT_HI, 3'h0, 8'hFF);
    rc(pca_pkg::SEL_CNT_LO, 3'h0, 8'hF0);
    wr(pca_pkg::SEL_CNT_HI, 3'h0, 8'h12);
    rc(pca_pkg::SEL_CNT_HI, 3'h0, 8'hFF);
    rc(pca_pkg::SEL_CNT_LO, 3'h0, 8'hF0);
    rc(pca_pkg::SEL_CNT_HI, 3'h0, 8'h12);
    wr(pca_pkg::SEL_CNT_HI, 3'h0, 8'hFF);
    wr(pca_pkg::SEL_MODE, 3'h0, 8'h09);
    @(posedge clk);
    gie <= 1'b1;
    grp <= 1'b1;
    wr(pca_pkg::SEL_CTRL, 3'h0, 8'h40);
    repeat (30) @(posedge clk);
    ck_irq(1'b1);
    rc(pca_pkg::SEL_CTRL, 3'h0, 8'hC0);
    @(posedge clk);
    gie <= 1'b0;
    ck_irq(1'b0);
    @(posedge clk);
    gie <= 1'b1;
    ck_irq(1'b1);
    wr(pca_pkg::SEL_CTRL, 3'h0, 8'h00);
    ck_irq(1'b0);
    wr(pca_pkg::SEL_MODE, 3'h0, 8'h08);
    $display("test overflow done");
    // Rising, falling and both-edge capture on modules 0 to 2
    wr(pca_pkg::SEL_MOD_CTL, 3'h0, 8'h20);
    wr(pca_pkg::SEL_MOD_CTL, 3'h1, 8'h10);
    wr(pca_pkg::SEL_MOD_CTL, 3'h2, 8'h30);
    wr(pca_pkg::SEL_CNT_LO, 3'h0, 8'h34);
    wr(pca_pkg::SEL_CNT_HI, 3'h0, 8'h12);
    @(posedge clk);
    lvl <= 5'h1F;
    // Edge needs four clocks to reach the capture; count must not move yet
    repeat (4) @(posedge clk);
    wr(pca_pkg::SEL_CNT_LO, 3'h0, 8'h78);
    wr(pca_pkg::SEL_CNT_HI, 3'h0, 8'h56);
    @(posedge clk);
    lvl <= 5'h00;
    repeat (8) @(posedge clk);
    for (int m = 0; m < 3; m++) begin
      rc(pca_pkg::SEL_MOD_LO, 3'(m), cap_ex[m][7:0]);
      rc(pca_pkg::SEL_MOD_HI, 3'(m), cap_ex[m][15:8]);
    end
    rc(pca_pkg::SEL_CTRL, 3'h0, 8'h07);
    wr(pca_pkg::SEL_CTRL, 3'h0, 8'h00);
    $display("test capture done");
    // Wrap during a read-modify-write is lost; software rebuilds the flag
    wr(pca_pkg::SEL_CNT_LO, 3'h0, 8'hFF);
    wr(pca_pkg::SEL_CNT_HI, 3'h0, 8'hFF);
    acc(1'b1, pca_pkg::SEL_CNT_LO, 3'h0, 8'h00);
    acc(1'b1, pca_pkg::SEL_CNT_HI, 3'h0, 8'h00);
    w = v;
    @(posedge clk);
    req.wr <= 1'b1;
    req.rmw <= 1'b1;
    req.sel <= pca_pkg::SEL_CTRL;
    req.wdata <= 8'h40;
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
    req <= '0;
    rc(pca_pkg::SEL_CTRL, 3'h0, 8'h40);
    acc(1'b1, pca_pkg::SEL_CNT_LO, 3'h0, 8'h00);
    acc(1'b1, pca_pkg::SEL_CNT_HI, 3'h0, 8'h00);
    `CHK({w, v}, 16'hFF00)
    wr(pca_pkg::SEL_CTRL, 3'h0, 8'hC0);
    rc(pca_pkg::SEL_CTRL, 3'h0, 8'hC0);
    wr(pca_pkg::SEL_CTRL, 3'h0, 8'h00);
    $display("test lost overflow done");
    // Software timer on module 3, toggling output on module 4
    wr(pca_pkg::SEL_MOD_CTL, 3'h3, 8'h49);
    wr(pca_pkg::SEL_MOD_LO, 3'h3, 8'h10);
    rc(pca_pkg::SEL_MOD_CTL, 3'h3, 8'h09);
    wr(pca_pkg::SEL_MOD_HI, 3'h3, 8'h00);
    rc(pca_pkg::SEL_MOD_CTL, 3'h3, 8'h49);
    wr(pca_pkg::SEL_MOD_CTL, 3'h4, 8'h4C);
    wr(pca_pkg::SEL_MOD_LO, 3'h4, 8'h10);
    wr(pca_pkg::SEL_MOD_HI, 3'h4, 8'h00);
    wr(pca_pkg::SEL_CNT_LO, 3'h0, 8'h00);
    wr(pca_pkg::SEL_CNT_HI, 3'h0, 8'h00);
    wr(pca_pkg::SEL_CTRL, 3'h0, 8'h40);
    repeat (40) @(posedge clk);
    ck_irq(1'b1);
    `CHK(line_out[4], 1'b1)
    acc(1'b1, pca_pkg::SEL_CTRL, 3'h0, 8'h00);
    `CHK(v[3], 1'b1)
    wr(pca_pkg::SEL_CTRL, 3'h0, 8'h00);
    $display("test compare done");
    give_verdict();
  end
endmodule : pca_top_bench
